/* File: gpib_opt_pkg.sv */
package gpib_opt_pkg;

   // Byte addresses on the register bus
   localparam logic [3:0] OFS_OPTION = 4'h0;   // Shared option port, write only
   localparam logic [3:0] OFS_AUX    = 4'h4;   // Auxiliary command port, write only
   localparam logic [3:0] OFS_STATUS = 4'h8;   // Status, read only

   // Select codes in the upper bits of an option byte
   localparam logic [2:0] SEL_B = 3'h5;        // Bits 7:5
   localparam logic [3:0] SEL_E = 4'hc;        // Bits 7:4
   localparam logic [3:0] SEL_F = 4'hd;        // Bits 7:4

   // Holdoff field positions
   localparam int E_TRIGGER   = 3;
   localparam int E_CLEAR     = 2;
   localparam int F_TALK      = 3;
   localparam int F_LISTEN    = 2;
   localparam int F_UNADDRESS = 1;
   localparam int F_GROUPS    = 0;

   // Auxiliary command codes
   localparam logic [7:0] AUX_SET_PP_FLAG   = 8'h01;
   localparam logic [7:0] AUX_CLEAR_PP_FLAG = 8'h02;
   localparam logic [7:0] AUX_CHANNEL_RESET = 8'h03;
   localparam logic [7:0] AUX_RELEASE_HOLD  = 8'h04;

   // Status bit positions
   localparam int ST_CIC     = 0;
   localparam int ST_UNC     = 1;
   localparam int ST_HOLDOFF = 2;
   localparam int ST_PP_FLAG = 3;
   localparam int ST_IST     = 4;

   // Reset values
   localparam logic [3:0] RST_E   = 4'h0;
   localparam logic [3:0] RST_F   = 4'h0;
   localparam logic [4:0] RST_OPT = 5'h00;

   // Bus command encodings, 7 bit
   localparam logic [6:0] CMD_GET = 7'h08;
   localparam logic [6:0] CMD_SDC = 7'h04;
   localparam logic [6:0] CMD_DCL = 7'h14;
   localparam logic [6:0] CMD_UNL = 7'h3f;
   localparam logic [6:0] CMD_UNT = 7'h5f;

   // Bus response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef struct packed
   {
      logic ist_source_select;
      logic irq_polarity_invert;
      logic listen_while_controller;
      logic serial_poll_end_flag;
      logic auto_take_control;
   } bus_options_t;

   typedef struct packed
   {
      logic       valid;     // One cycle pulse
      logic       from_self; // Byte sourced by this device
      logic [7:0] data;      // Command byte as on the bus
   } gpib_cmd_t;

endpackage

/* File: gpib_option_and_holdoff_regs.sv */
module gpib_option_and_holdoff_regs
   import gpib_opt_pkg::*;
#(
   parameter int ADDR_W = 4
)
(
   input  wire logic              CLK_IN,
   input  wire logic              RESETN_IN,
   // Register bus write address
   input  wire logic              S_AXI_AWVALID_IN,
   output      logic              S_AXI_AWREADY_OUT,
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
   // Register bus write data
   input  wire logic              S_AXI_WVALID_IN,
   output      logic              S_AXI_WREADY_OUT,
   input  wire logic [31:0]       S_AXI_WDATA_IN,
   input  wire logic [3:0]        S_AXI_WSTRB_IN,
   // Register bus write response
   output      logic              S_AXI_BVALID_OUT,
   input  wire logic              S_AXI_BREADY_IN,
   output      logic [1:0]        S_AXI_BRESP_OUT,
   // Register bus read address
   input  wire logic              S_AXI_ARVALID_IN,
   output      logic              S_AXI_ARREADY_OUT,
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
   // Register bus read data
   output      logic              S_AXI_RVALID_OUT,
   input  wire logic              S_AXI_RREADY_IN,
   output      logic [31:0]       S_AXI_RDATA_OUT,
   output      logic [1:0]        S_AXI_RRESP_OUT,
   // Command path from the acceptor logic, same clock
   input  wire gpib_cmd_t         CMD_IN,
   input  wire logic              LISTEN_ADDRESSED_IN,
   input  wire logic              CIC_ACTIVE_IN,
   output      logic              CMD_ACCEPT_OUT,
   output      logic              DAC_HOLDOFF_OUT,
   // Controller passing, same clock
   input  wire logic              CTRL_PASSED_IN,
   input  wire logic              CTRL_LOST_IN,
   output      logic              CIC_STATUS_OUT,
   // Poll and interrupt
   input  wire logic              SRQ_STATE_IN,
   input  wire logic              IRQ_REQ_IN,
   output      logic              IST_OUT,
   output      logic              SPOLL_EOI_OUT,
   output      logic              INT_PIN_OUT
);

   // Decoder needs at least the status word
   if (ADDR_W < 4)
   begin
      $error("ADDR_W must be at least 4");
   end

   // Command class decoders, bit 7 is parity on the bus and ignored
   function automatic logic is_talk_addr(input logic [7:0] b);
      is_talk_addr = (b[6:5] == 2'h2) && (b[6:0] != CMD_UNT);
   endfunction
   function automatic logic is_listen_addr(input logic [7:0] b);
      is_listen_addr = (b[6:5] == 2'h1) && (b[6:0] != CMD_UNL);
   endfunction
   function automatic logic is_group_cmd(input logic [7:0] b);
      // Addressed, universal and secondary groups
      is_group_cmd = (b[6:5] == 2'h0) || (b[6:5] == 2'h3);
   endfunction

   // Reset release synchroniser
   logic [1:0]   rst_sync_r;       // Release shift chain
   logic         rst_n;            // Synchronised reset for all logic

   // Stored option state, select bits never kept
   bus_options_t opt_r;            // Option register B contents
   logic [3:0]   hold_e_r;         // Holdoff enables E, bits 3:0
   logic [3:0]   hold_f_r;         // Holdoff enables F, bits 3:0

   // Device state
   logic         pp_flag_r;        // Internal parallel poll flag
   logic         unc_r;            // Unrecognized command flag, sticky
   logic         holdoff_r;        // Data accepted holdoff in force
   logic         cic_r;            // Controller in charge status bit
   logic         ist_r;            // Registered ist message
   logic         int_pin_r;        // Registered interrupt pin level
   logic         accept_r;         // Accepted command pulse

   // Bus slave state
   logic              aw_have_r;   // Write address captured
   logic              w_have_r;    // Write data captured
   logic [ADDR_W-1:0] aw_addr_r;   // Captured write address
   logic [31:0]       w_data_r;    // Captured write data
   logic              w_lane0_r;   // Low byte lane enabled
   logic              bvalid_r;    // Write response pending
   logic [1:0]        bresp_r;     // Write response code
   logic              rvalid_r;    // Read data pending
   logic [31:0]       rdata_r;     // Read data word
   logic [1:0]        rresp_r;     // Read response code

   // Decoded write strobes
   logic         wr_fire;          // Both halves of a write held
   logic         wr_option;        // Write to shared option port
   logic         wr_aux;           // Write to aux command port
   logic         wr_mapped;        // Address decodes
   logic [7:0]   wr_byte;          // Low byte of the write
   logic         ld_b;             // Load option register B
   logic         ld_e;             // Load holdoff E
   logic         ld_f;             // Load holdoff F
   logic         aux_set_pp;       // Set poll flag command
   logic         aux_clr_pp;       // Clear poll flag command
   logic         aux_channel_reset_cmd;       // Channel reset command
   logic         aux_release;      // Release holdoff command
   // Decoded read side
   logic         rd_fire;          // Read address taken
   logic         rd_status;        // Read hits status
   logic         rd_mapped;        // Read address decodes
   logic [31:0]  status_word;      // Live status view

   // Command path
   logic         own_ignored;      // Own byte dropped while controller
   logic         cmd_taken;        // Byte accepted by this device
   logic [6:0]   cmd7;             // Seven bit command code
   logic         hit_e;            // Byte matches an enabled E class
   logic         hit_f;            // Byte matches an enabled F class
   logic         hold_hit;         // Byte must be held off

   // Two stage release so reset leaves on a clock edge
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end

   assign rst_n = rst_sync_r[1];
   // Write path decode; a write without the low byte lane changes nothing
   assign wr_fire     = aw_have_r && w_have_r && !bvalid_r;
   assign wr_byte     = w_data_r[7:0];
   assign wr_option   = wr_fire && w_lane0_r && (aw_addr_r[3:0] == OFS_OPTION);
   assign wr_aux      = wr_fire && w_lane0_r && (aw_addr_r[3:0] == OFS_AUX);
   assign wr_mapped   = (aw_addr_r[3:0] == OFS_OPTION) || (aw_addr_r[3:0] == OFS_AUX)
                        || (aw_addr_r[3:0] == OFS_STATUS);
   assign ld_b        = wr_option && (wr_byte[7:5] == SEL_B);
   assign ld_e        = wr_option && (wr_byte[7:4] == SEL_E);
   assign ld_f        = wr_option && (wr_byte[7:4] == SEL_F);
   assign aux_set_pp  = wr_aux && (wr_byte == AUX_SET_PP_FLAG);
   assign aux_clr_pp  = wr_aux && (wr_byte == AUX_CLEAR_PP_FLAG);
   assign aux_channel_reset_cmd  = wr_aux && (wr_byte == AUX_CHANNEL_RESET);
   assign aux_release = wr_aux && (wr_byte == AUX_RELEASE_HOLD);

   // Read path decode; option port reads zero, its contents stay hidden
   assign rd_fire     = S_AXI_ARVALID_IN && !rvalid_r;
   assign rd_status   = S_AXI_ARADDR_IN[3:0] == OFS_STATUS;
   assign rd_mapped   = rd_status || (S_AXI_ARADDR_IN[3:0] == OFS_OPTION)
                        || (S_AXI_ARADDR_IN[3:0] == OFS_AUX);

   // Status view
   always_comb
   begin
      status_word             = 32'h0;
      status_word[ST_CIC]     = cic_r;
      status_word[ST_UNC]     = unc_r;
      status_word[ST_HOLDOFF] = holdoff_r;
      status_word[ST_PP_FLAG] = pp_flag_r;
      status_word[ST_IST]     = ist_r;
   end

   // Command acceptance; own bytes as controller need the listen option
   assign cmd7        = CMD_IN.data[6:0];
   assign own_ignored = CMD_IN.from_self && CIC_ACTIVE_IN
                        && !opt_r.listen_while_controller;
   assign cmd_taken   = CMD_IN.valid && !own_ignored;

   // Trigger and selected clear only count when listen addressed
   assign hit_e = (hold_e_r[E_TRIGGER] && (cmd7 == CMD_GET)
                     && LISTEN_ADDRESSED_IN)
                  || (hold_e_r[E_CLEAR] && ((cmd7 == CMD_DCL)
                     || ((cmd7 == CMD_SDC) && LISTEN_ADDRESSED_IN)));
   assign hit_f = (hold_f_r[F_TALK] && is_talk_addr(CMD_IN.data))
                  || (hold_f_r[F_LISTEN] && is_listen_addr(CMD_IN.data))
                  || (hold_f_r[F_UNADDRESS]
                     && ((cmd7 == CMD_UNT) || (cmd7 == CMD_UNL)))
                  || (hold_f_r[F_GROUPS] && is_group_cmd(CMD_IN.data));
   assign hold_hit = cmd_taken && (hit_e || hit_f);

   // Write address and data taken in either order
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_have_r <= 1'b0;
         aw_addr_r <= '0;
      end
      else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
      begin
         aw_have_r <= 1'b1;
         aw_addr_r <= S_AXI_AWADDR_IN;
      end
      else if (wr_fire)
         aw_have_r <= 1'b0;
   end

   // Write data capture
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         w_have_r  <= 1'b0;
         w_data_r  <= 32'h0;
         w_lane0_r <= 1'b0;
      end
      else if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
      begin
         w_have_r  <= 1'b1;
         w_data_r  <= S_AXI_WDATA_IN;
         w_lane0_r <= S_AXI_WSTRB_IN[0];
      end
      else if (wr_fire)
         w_have_r <= 1'b0;
   end

   // Write response, unmapped addresses get a decode error
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_mapped ? RESP_OKAY : RESP_DECERR;
      end
      else if (S_AXI_BREADY_IN)
         bvalid_r <= 1'b0;
   end

   // Read answer one cycle after the address is taken
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0;
         rresp_r  <= RESP_OKAY;
      end
      else if (rd_fire)
      begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_status ? status_word : 32'h0;
         rresp_r  <= rd_mapped ? RESP_OKAY : RESP_DECERR;
      end
      else if (S_AXI_RREADY_IN)
         rvalid_r <= 1'b0;
   end

   // Option bits; select code itself is dropped
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
         opt_r <= bus_options_t'(RST_OPT);
      else if (ld_b)
         opt_r <= bus_options_t'(wr_byte[4:0]);
   end

   // Holdoff enables; bits 1:0 of E are fixed zero and never stored
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hold_e_r <= RST_E;
         hold_f_r <= RST_F;
      end
      else if (aux_channel_reset_cmd)
      begin
         hold_e_r <= RST_E;
         hold_f_r <= RST_F;
      end
      else
      begin
         if (ld_e)
            hold_e_r <= {wr_byte[3:2], 2'h0};
         if (ld_f)
            hold_f_r <= wr_byte[3:0];
      end
   end

   // Poll flag moved only by the two host commands
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
         pp_flag_r <= 1'b0;
      else if (aux_set_pp)
         pp_flag_r <= 1'b1;
      else if (aux_clr_pp)
         pp_flag_r <= 1'b0;
   end

   // Sticky flag cleared by reading status; a new hit beats the clear
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
         unc_r <= 1'b0;
      else if (hold_hit)
         unc_r <= 1'b1;
      else if (rd_fire && rd_status)
         unc_r <= 1'b0;
   end

   // Holdoff persists until released; a hit in the release cycle wins
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
         holdoff_r <= 1'b0;
      else if (hold_hit)
         holdoff_r <= 1'b1;
      else if (aux_release || aux_channel_reset_cmd)
         holdoff_r <= 1'b0;
   end

   // Controller status; passing only counts with the auto option
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
         cic_r <= 1'b0;
      else if (CTRL_PASSED_IN && opt_r.auto_take_control)
         cic_r <= 1'b1;
      else if (CTRL_LOST_IN || aux_channel_reset_cmd)
         cic_r <= 1'b0;
   end

   // Registered pins keep glitches off the bus and interrupt line
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ist_r     <= 1'b0;
         int_pin_r <= 1'b1;
         accept_r  <= 1'b0;
      end
      else
      begin
         ist_r     <= opt_r.ist_source_select ? SRQ_STATE_IN
                                              : pp_flag_r;
         int_pin_r <= opt_r.irq_polarity_invert ? IRQ_REQ_IN
                                                : !IRQ_REQ_IN;
         accept_r  <= cmd_taken;
      end
   end

   // Bus handshake outputs, combinational ready
   assign S_AXI_AWREADY_OUT = !aw_have_r && !bvalid_r;
   assign S_AXI_WREADY_OUT  = !w_have_r && !bvalid_r;
   assign S_AXI_ARREADY_OUT = !rvalid_r;
   assign S_AXI_BVALID_OUT  = bvalid_r;
   assign S_AXI_BRESP_OUT   = bresp_r;
   assign S_AXI_RVALID_OUT  = rvalid_r;
   assign S_AXI_RDATA_OUT   = rdata_r;
   assign S_AXI_RRESP_OUT   = rresp_r;

   // Device outputs, all from flip-flops
   assign CMD_ACCEPT_OUT  = accept_r;
   assign DAC_HOLDOFF_OUT = holdoff_r;
   assign CIC_STATUS_OUT  = cic_r;
   assign IST_OUT         = ist_r;
   assign SPOLL_EOI_OUT   = opt_r.serial_poll_end_flag;
   assign INT_PIN_OUT     = int_pin_r;

endmodule

/* File: gpib_option_and_holdoff_regs_asserts.sv */
module gpib_option_and_holdoff_regs_asserts
   import gpib_opt_pkg::*;
#(
   parameter int ADDR_W = 4
)
(
   input wire logic              CLK_IN,
   input wire logic              RESETN_IN,
   input wire logic              S_AXI_AWVALID_IN,
   input wire logic              S_AXI_AWREADY_OUT,
   input wire logic              S_AXI_WVALID_IN,
   input wire logic              S_AXI_WREADY_OUT,
   input wire logic              S_AXI_BVALID_OUT,
   input wire logic              S_AXI_ARVALID_IN,
   input wire logic              S_AXI_ARREADY_OUT,
   input wire logic              S_AXI_RVALID_OUT,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
   input wire logic [31:0]       S_AXI_RDATA_OUT,
   input wire gpib_cmd_t         CMD_IN,
   input wire logic              CMD_ACCEPT_OUT,
   input wire logic              DAC_HOLDOFF_OUT,
   input wire logic              CTRL_PASSED_IN,
   input wire logic              CIC_STATUS_OUT,
   input wire logic              IRQ_REQ_IN,
   input wire logic              INT_PIN_OUT,
   input wire logic              SPOLL_EOI_OUT
);
   timeunit 1ns;
   timeprecision 1ps;

   // One clock domain, so one clocking and one disable for all
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   // Bytes from other talkers are never dropped
   a_accept_ext: assert property (CMD_IN.valid && !CMD_IN.from_self |=> CMD_ACCEPT_OUT)
      else $error("foreign command byte not accepted");
   a_accept_cause: assert property (CMD_ACCEPT_OUT |-> $past(CMD_IN.valid))
      else $error("accept without a command byte");
   // A holdoff only starts on an accepted byte
   a_hold_rise: assert property ($rose(DAC_HOLDOFF_OUT) |-> CMD_ACCEPT_OUT)
      else $error("holdoff without accepted byte");
   // Only a host write ends a holdoff
   a_hold_release: assert property ($fell(DAC_HOLDOFF_OUT) |-> $rose(S_AXI_BVALID_OUT))
      else $error("holdoff dropped without host command");
   a_cic_cause: assert property ($rose(CIC_STATUS_OUT) |-> $past(CTRL_PASSED_IN))
      else $error("controller status set without pass");
   // Pin moves only after a request change or an option write
   a_int_cause: assert property ($changed(INT_PIN_OUT) |->
      $past(IRQ_REQ_IN) != $past(IRQ_REQ_IN, 2)
      || ($past(S_AXI_BVALID_OUT) && !$past(S_AXI_BVALID_OUT, 2)))
      else $error("interrupt pin moved without cause");
   a_eoi_cause: assert property ($changed(SPOLL_EOI_OUT) |-> $rose(S_AXI_BVALID_OUT)
      || ($past(S_AXI_BVALID_OUT) && !$past(S_AXI_BVALID_OUT, 2)))
      else $error("poll end level moved without write");
   // Halves held one edge, response raised the next, seen two edges on
   a_write_answer: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT
      && S_AXI_WVALID_IN && S_AXI_WREADY_OUT |-> ##2 S_AXI_BVALID_OUT)
      else $error("write response late");
   // Write-only port must read back as zero
   a_read_zero: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT
      && S_AXI_ARADDR_IN == ADDR_W'(OFS_OPTION) |=> S_AXI_RVALID_OUT && S_AXI_RDATA_OUT == 32'h0)
      else $error("option port read not zero");
endmodule

/* File: gpib_ctrl_model.sv */
module gpib_ctrl_model
   import gpib_opt_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic accept_in,
   output gpib_cmd_t cmd_out,
   output logic      addressed_out,
   output logic      cic_out,
   output logic      passed_out,
   output logic      lost_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus: no byte, control not moving
   initial
   begin
      cmd_out = '{valid: 1'b0, from_self: 1'b0, data: 8'h5a};
      addressed_out = 1'b0;
      cic_out = 1'b0;
      passed_out = 1'b0;
      lost_out = 1'b0;
   end

   // One byte for one cycle; released lines flip so a stale byte never matches
   task automatic send(input logic [7:0] b, input logic s, input logic a, input logic c,
                       output logic took);
      @(posedge clk_in);
      cmd_out <= '{valid: 1'b1, from_self: s, data: b};
      addressed_out <= a;
      cic_out <= c;
      @(posedge clk_in);
      cmd_out <= '{valid: 1'b0, from_self: 1'b0, data: ~b};
      #1 took = accept_in;
   endtask

   // Control handed over or taken away, one cycle pulse
   task automatic hand(input logic p, input logic l);
      @(posedge clk_in);
      passed_out <= p;
      lost_out <= l;
      @(posedge clk_in);
      passed_out <= 1'b0;
      lost_out <= 1'b0;
      #1;
   endtask
endmodule

/* File: gpib_option_and_holdoff_regs_test.sv */
bind gpib_option_and_holdoff_regs gpib_option_and_holdoff_regs_asserts #(.ADDR_W(ADDR_W)) chk (
   .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .S_AXI_AWVALID_IN(S_AXI_AWVALID_IN),
   .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT), .S_AXI_WVALID_IN(S_AXI_WVALID_IN),
   .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT), .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
   .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN), .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
   .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_ARADDR_IN(S_AXI_ARADDR_IN),
   .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT), .CMD_IN(CMD_IN), .CMD_ACCEPT_OUT(CMD_ACCEPT_OUT),
   .DAC_HOLDOFF_OUT(DAC_HOLDOFF_OUT), .CTRL_PASSED_IN(CTRL_PASSED_IN),
   .CIC_STATUS_OUT(CIC_STATUS_OUT), .IRQ_REQ_IN(IRQ_REQ_IN), .INT_PIN_OUT(INT_PIN_OUT),
   .SPOLL_EOI_OUT(SPOLL_EOI_OUT)
);

module gpib_option_and_holdoff_regs_test
   import gpib_opt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 0, rstn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, srq = 0, irq = 0;
   logic [3:0]  awa = 4'h0, ara = 4'h0;
   logic [31:0] wd = 32'h0, rdat;
   logic        awr, wr_rdy, bv, arr, rv, la, cic, acc, hold, cp, cl, cics, ist, eoi, intp;
   logic [1:0]  bresp, rresp;
   gpib_cmd_t   cmd;
   int          fail_count = 0, checks = 0;

   always #2.5 clk = ~clk;

   gpib_option_and_holdoff_regs dut (
      .CLK_IN(clk), .RESETN_IN(rstn), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
      .S_AXI_AWADDR_IN(awa), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_rdy),
      .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hf), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
      .S_AXI_BRESP_OUT(bresp), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
      .S_AXI_ARADDR_IN(ara), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr),
      .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rresp), .CMD_IN(cmd),
      .LISTEN_ADDRESSED_IN(la), .CIC_ACTIVE_IN(cic), .CMD_ACCEPT_OUT(acc),
      .DAC_HOLDOFF_OUT(hold), .CTRL_PASSED_IN(cp), .CTRL_LOST_IN(cl), .CIC_STATUS_OUT(cics),
      .SRQ_STATE_IN(srq), .IRQ_REQ_IN(irq), .IST_OUT(ist), .SPOLL_EOI_OUT(eoi), .INT_PIN_OUT(intp)
   );

   gpib_ctrl_model bus (.clk_in(clk), .accept_in(acc), .cmd_out(cmd), .addressed_out(la),
      .cic_out(cic), .passed_out(cp), .lost_out(cl));

   task automatic end_sim;
      if (fail_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
      end
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %0t word %h expected %h", $time, got, exp);
      end
   endtask

   // Settle point just after an edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One bus transfer; handshakes judged on the negedge, released after the edge
   task automatic axi(input logic rd, input logic [3:0] a, input logic [7:0] d,
                      output logic [31:0] q, output logic [1:0] r);
      logic ta, tw, dn;
      int   n;
      dn = 0;
      n = 0;
      @(posedge clk);
      if (rd)
      begin
         arv <= 1'b1;
         ara <= a;
         rr <= 1'b1;
      end
      else
      begin
         awv <= 1'b1;
         awa <= a;
         wv <= 1'b1;
         wd <= {24'h0, d};
         br <= 1'b1;
      end
      while (!dn && n < 64)
      begin
         @(negedge clk);
         n++;
         ta = rd ? arv && arr : awv && awr;
         tw = wv && wr_rdy;
         dn = rd ? rv && rr : bv && br;
         q = rdat;
         r = rd ? rresp : bresp;
         @(posedge clk);
         if (ta)
         begin
            arv <= 1'b0;
            awv <= 1'b0;
         end
         if (tw)
            wv <= 1'b0;
         if (dn)
         begin
            rr <= 1'b0;
            br <= 1'b0;
         end
      end
      if (!dn)
      begin
         fail_count++;
         $display("MISMATCH %0t no bus answer", $time);
         end_sim;
      end
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic [1:0]  r;
      axi(1'b0, a, d, q, r);
      cmp_word({30'h0, r}, {30'h0, RESP_OKAY});
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                         input logic [1:0] er);
      logic [31:0] q;
      logic [1:0]  r;
      axi(1'b1, a, 8'h0, q, r);
      cmp_word(q & m, e);
      cmp_word({30'h0, r}, {30'h0, er});
   endtask

   function automatic logic exp_int(input logic v, input logic q);
      return v ? q : !q;
   endfunction

   // Expected holdoff for an enable byte, a command byte and listen addressing
   function automatic logic exp_hold(input logic [7:0] w, input logic [7:0] c, input logic a);
      logic [6:0] m;
      m = c[6:0];
      if (w[7:4] == SEL_E)
         return (w[E_TRIGGER] && a && m == CMD_GET)
            || (w[E_CLEAR] && (m == CMD_DCL || (a && m == CMD_SDC)));
      return (w[F_TALK] && m[6:5] == 2'b10 && m != CMD_UNT)
         || (w[F_LISTEN] && m[6:5] == 2'b01 && m != CMD_UNL)
         || (w[F_UNADDRESS] && (m == CMD_UNT || m == CMD_UNL))
         || (w[F_GROUPS] && (m[6:5] == 2'b00 || m[6:5] == 2'b11));
   endfunction

   initial
   begin
      logic [4:0]  o;
      logic [16:0] t;
      logic [31:0] q;
      logic [1:0]  r;
      logic        p;
      logic        e;
      static logic [16:0] tbl [11] = '{17'h1c808, 17'h0c414, 17'h1c404, 17'h1c308, 17'h0d845,
         17'h0d42a, 17'h0d25f, 17'h0d23f, 17'h0d111, 17'h0d16a, 17'h0d745};
      void'($urandom(72));
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      tick(4);
      // Fresh state, then an unmapped place
      rd_chk(OFS_STATUS, 32'h1f, 32'h0, RESP_OKAY);
      rd_chk(4'hc, 32'hffffffff, 32'h0, RESP_DECERR);
      axi(1'b0, 4'hc, 8'hdf, q, r);
      cmp_word({30'h0, r}, {30'h0, RESP_DECERR});
      // Random option bytes; a foreign select code must leave them alone
      for (int i = 0; i < 10; i++)
      begin
         o = 5'($urandom);
         p = 1'($urandom);
         wr(OFS_OPTION, {SEL_B, o});
         wr(OFS_AUX, p ? AUX_SET_PP_FLAG : AUX_CLEAR_PP_FLAG);
         @(posedge clk);
         irq <= 1'($urandom);
         srq <= 1'($urandom);
         tick(2);
         cmp_bit(intp, exp_int(o[3], irq));
         cmp_bit(ist, o[4] ? srq : p);
         cmp_bit(eoi, o[1]);
         wr(OFS_OPTION, {3'h7, ~o});
         cmp_bit(eoi, o[1]);
         rd_chk(OFS_OPTION, 32'hffffffff, 32'h0, RESP_OKAY);
      end
      // Corner table first, then random enables and bytes
      for (int i = 0; i < 31; i++)
      begin
         t = i < 11 ? tbl[i] : {1'($urandom), 3'h6, 1'($urandom), 4'($urandom), 8'($urandom)};
         e = exp_hold(t[15:8], t[7:0], t[16]);
         wr(OFS_AUX, AUX_CHANNEL_RESET);
         wr(OFS_OPTION, t[15:8]);
         bus.send(t[7:0], 1'b0, t[16], 1'b0, p);
         cmp_bit(p, 1'b1);
         cmp_bit(hold, e);
         rd_chk(OFS_STATUS, 32'h6, {29'h0, e, e, 1'b0}, RESP_OKAY);
         tick(6);
         cmp_bit(hold, e);
         wr(OFS_AUX, AUX_RELEASE_HOLD);
         cmp_bit(hold, 1'b0);
      end
      // Own bytes as controller, and automatic take control
      for (int b = 0; b < 2; b++)
      begin
         wr(OFS_OPTION, {SEL_B, 2'b00, 1'(b), 1'b0, 1'(b)});
         bus.send(8'h2a, 1'b1, 1'b0, 1'b1, p);
         cmp_bit(p, 1'(b));
         bus.hand(1'b1, 1'b0);
         cmp_bit(cics, 1'(b));
         rd_chk(OFS_STATUS, 32'h1, 32'(b), RESP_OKAY);
         bus.hand(1'b0, 1'b1);
         cmp_bit(cics, 1'b0);
      end
      // Enables cleared by channel reset, then by a hardware reset
      for (int m = 0; m < 2; m++)
      begin
         wr(OFS_OPTION, 8'hcc);
         wr(OFS_OPTION, 8'hdf);
         if (m == 0)
            wr(OFS_AUX, AUX_CHANNEL_RESET);
         else
         begin
            @(posedge clk);
            rstn <= 1'b0;
            irq <= 1'b0;
            repeat (3) @(posedge clk);
            rstn <= 1'b1;
            tick(4);
         end
         bus.send(8'h08, 1'b0, 1'b1, 1'b0, p);
         bus.send(8'h45, 1'b0, 1'b0, 1'b0, p);
         cmp_bit(hold, 1'b0);
      end
      end_sim;
   end
endmodule
